/* File: core/flash_status_pkg.sv */
// constants, commands and types for the status register one logic
//
// Overview of operation
// - lock bit set and protect pin low: lock and range bits frozen, writes refused
// - protect pin high or lock clear: register write may change lock and range
// - program failure flag set on failed program or protected/locked target
// - failure flags read-only; register write ignores them; only clear-status, software reset or hardware reset clears
// - erase failure on failed erase or protected sector; whole-array erase ignores protected sector
// - range bits volatile or nonvolatile per config; nonzero range blocks region
// - whole-array erase runs only with all three range bits zero
// - program, erase and register write need the write-permit latch set
// - permit-set sets latch, permit-clear clears it, register write data does not load it
// - successful program, write or erase clears the latch; failure may keep it
// - latch is zero after power-up, hardware reset and software reset
// - while busy only status reads, suspends, clear-status, software reset taken
// - erase suspend only during erase, program suspend only during program
// - flags update while busy; a set flag keeps busy until clear-status or software reset
// - resets restore volatile bits; nonvolatile bits keep stored values
// - status read uses 05h and register write uses 01h
// - volatility config bit one selects volatile range bits, zero nonvolatile
// - protection freeze locks the current range bits against change
package flash_status_pkg;

	// command codes
	localparam logic [7:0] CMD_READ_STATUS_ONE   = 8'h05;
	localparam logic [7:0] CMD_READ_STATUS_TWO   = 8'h07;
	localparam logic [7:0] CMD_WRITE_REGISTERS   = 8'h01;
	localparam logic [7:0] CMD_WRITE_PERMIT_SET  = 8'h06;
	localparam logic [7:0] CMD_WRITE_PERMIT_CLR  = 8'h04;
	localparam logic [7:0] CMD_CLEAR_STATUS      = 8'h30;
	localparam logic [7:0] CMD_ERASE_SUSPEND     = 8'h75;
	localparam logic [7:0] CMD_PROGRAM_SUSPEND   = 8'h85;
	localparam logic [7:0] CMD_SOFTWARE_RESET    = 8'hf0;
	localparam logic [7:0] CMD_PAGE_PROGRAM      = 8'h02;
	localparam logic [7:0] CMD_SECTOR_ERASE      = 8'hd8;
	localparam logic [7:0] CMD_WHOLE_ARRAY_ERASE = 8'h60;

	// status register one field positions
	localparam int unsigned BIT_LOCK     = 7;
	localparam int unsigned BIT_PROG_ERR = 6;
	localparam int unsigned BIT_ERASE_ERR = 5;
	localparam int unsigned BIT_RANGE_HI = 4;
	localparam int unsigned BIT_RANGE_LO = 2;
	localparam int unsigned BIT_PERMIT   = 1;
	localparam int unsigned BIT_BUSY     = 0;

	// reset values of volatile bits
	localparam logic [2:0] RANGE_VOL_RESET = 3'h7;
	localparam logic [7:0] STATUS_TWO_VALUE = 8'h00;

	// serial frame bit counts
	localparam logic [4:0] CNT_FIRST_BYTE_LAST  = 5'h07;
	localparam logic [4:0] CNT_SECOND_BYTE_LAST = 5'h0f;

	// operation handed to the array engine
	typedef enum logic [1:0] {
		KIND_PROGRAM = 2'b00,
		KIND_ERASE   = 2'b01,
		KIND_WHOLE   = 2'b10,
		KIND_WRITE   = 2'b11
	} op_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_PROG   = 3'b001,
		ST_ERASE  = 3'b010,
		ST_WHOLE  = 3'b011,
		ST_WRITE  = 3'b100,
		ST_FAILED = 3'b101
	} op_state_t;

endpackage : flash_status_pkg

/* File: core/flash_status_register_logic.sv */
// status register one: serial command front end and status/protect core
`timescale 1ns/1ps
module flash_status_register_logic (
	// core clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_sys_rst,
	// serial link
	input  wire logic       i_spi_clk,
	input  wire logic       i_cs_n,
	input  wire logic       i_mosi,
	input  wire logic       i_wp_n,
	output logic            o_miso,
	output logic            o_miso_oe,
	// configuration bits
	input  wire logic       i_protect_volatility_select,
	input  wire logic       i_protect_freeze,
	// nonvolatile image: lock bit then range bits
	input  wire logic [3:0] i_nv_image,
	output logic      [3:0] o_nv_image,
	// array engine
	input  wire logic       i_op_done,
	input  wire logic       i_op_fail,
	input  wire logic       i_target_protected,
	output logic            o_op_start,
	output logic      [1:0] o_op_kind,
	output logic            o_erase_suspend,
	output logic            o_program_suspend,
	output logic            o_soft_reset,
	output logic      [2:0] o_protect_range,
	output logic      [7:0] o_status
);

	// link domain
	logic [4:0] bit_cnt;
	logic [6:0] shift_in;
	logic [7:0] cmd_hold;
	logic [7:0] data_hold;
	logic       cmd_tgl;
	logic       read_one;
	logic       read_two;
	logic [7:0] status_link;
	logic       shadow_req_s1;
	logic       shadow_req_s2;
	logic       shadow_ack;
	logic [7:0] rd_byte;
	logic [7:0] byte_in;

	// core domain
	logic       wp_s1;
	logic       wp_s2;
	logic       cmd_s1;
	logic       cmd_s2;
	logic       cmd_seen;
	logic       ack_s1;
	logic       ack_s2;
	logic       shadow_req;
	logic [7:0] shadow;
	flash_status_pkg::op_state_t state;
	flash_status_pkg::op_state_t next_state;
	logic       permit;
	logic       prog_err;
	logic       erase_err;
	logic       lock;
	logic [2:0] range_nv;
	logic [2:0] range_vol;
	logic [2:0] range_eff;
	logic [7:0] status_now;
	logic       cmd_new;
	logic       busy;
	logic       allowed;
	logic       hw_protected;
	logic       is_cmd_wrr;
	logic       go_prog;
	logic       go_erase;
	logic       go_whole;
	logic       go_write;
	logic       go_reset;
	logic       go_clear;
	logic       fail_prog;
	logic       fail_erase;
	logic       fail_write;
	logic       done_ok;

	assign byte_in = {shift_in, i_mosi};

	// frame counter restarts whenever chip select goes high
	always_ff @(posedge i_spi_clk or posedge i_cs_n) begin
		if (i_cs_n) begin
			bit_cnt <= 5'h00;
		end else begin
			bit_cnt <= {bit_cnt[4] | (&bit_cnt[3:0]), bit_cnt[3:0] + 4'h1};
		end
	end

	always_ff @(posedge i_spi_clk) begin
		shift_in <= byte_in[6:0];
	end

	// command and data bytes held stable while the toggle crosses
	always_ff @(posedge i_spi_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cmd_hold  <= 8'h00;
			data_hold <= 8'h00;
			cmd_tgl   <= 1'b0;
		end else if (bit_cnt == flash_status_pkg::CNT_FIRST_BYTE_LAST) begin
			cmd_hold <= byte_in;
			if (byte_in != flash_status_pkg::CMD_WRITE_REGISTERS) begin
				cmd_tgl <= ~cmd_tgl;
			end
		end else if (bit_cnt == flash_status_pkg::CNT_SECOND_BYTE_LAST &&
				cmd_hold == flash_status_pkg::CMD_WRITE_REGISTERS) begin
			data_hold <= byte_in;
			cmd_tgl   <= ~cmd_tgl;
		end
	end

	always_ff @(posedge i_spi_clk or posedge i_cs_n) begin
		if (i_cs_n) begin
			read_one <= 1'b0;
			read_two <= 1'b0;
		end else if (bit_cnt == flash_status_pkg::CNT_FIRST_BYTE_LAST) begin
			read_one <= (byte_in == flash_status_pkg::CMD_READ_STATUS_ONE);
			read_two <= (byte_in == flash_status_pkg::CMD_READ_STATUS_TWO);
		end
	end

	// status snapshot arrives by request/acknowledge handshake
	always_ff @(posedge i_spi_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			shadow_req_s1 <= 1'b0;
			shadow_req_s2 <= 1'b0;
			shadow_ack    <= 1'b0;
			status_link   <= 8'h00;
		end else begin
			shadow_req_s1 <= shadow_req;
			shadow_req_s2 <= shadow_req_s1;
			if (shadow_req_s2 != shadow_ack) begin
				status_link <= shadow;
				shadow_ack  <= ~shadow_ack;
			end
		end
	end

	assign rd_byte = read_two ? flash_status_pkg::STATUS_TWO_VALUE : status_link;

	// output changes on the falling edge; each bit reads the current snapshot
	always_ff @(negedge i_spi_clk or posedge i_cs_n) begin
		if (i_cs_n) begin
			o_miso    <= 1'b0;
			o_miso_oe <= 1'b0;
		end else begin
			o_miso_oe <= read_one | read_two;
			o_miso    <= rd_byte[~bit_cnt[2:0]];
		end
	end

	// core side synchronisers
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			wp_s1    <= 1'b1;
			wp_s2    <= 1'b1;
			cmd_s1   <= 1'b0;
			cmd_s2   <= 1'b0;
			cmd_seen <= 1'b0;
			ack_s1   <= 1'b0;
			ack_s2   <= 1'b0;
		end else begin
			wp_s1    <= i_wp_n;
			wp_s2    <= wp_s1;
			cmd_s1   <= cmd_tgl;
			cmd_s2   <= cmd_s1;
			cmd_seen <= cmd_s2;
			ack_s1   <= shadow_ack;
			ack_s2   <= ack_s1;
		end
	end

	assign cmd_new      = cmd_s2 ^ cmd_seen;
	assign busy         = (state != flash_status_pkg::ST_IDLE);
	assign hw_protected = lock & ~wp_s2;
	assign range_eff    = i_protect_volatility_select ? range_vol
		: range_nv;
	assign is_cmd_wrr   = (cmd_hold == flash_status_pkg::CMD_WRITE_REGISTERS);

	// busy filter: only the listed commands pass while an operation runs
	always_comb begin
		case (cmd_hold)
			flash_status_pkg::CMD_READ_STATUS_ONE,
			flash_status_pkg::CMD_READ_STATUS_TWO,
			flash_status_pkg::CMD_CLEAR_STATUS,
			flash_status_pkg::CMD_SOFTWARE_RESET: allowed = cmd_new;
			flash_status_pkg::CMD_ERASE_SUSPEND:  allowed = cmd_new &
				(state == flash_status_pkg::ST_ERASE ||
				state == flash_status_pkg::ST_WHOLE);
			flash_status_pkg::CMD_PROGRAM_SUSPEND: allowed = cmd_new &
				(state == flash_status_pkg::ST_PROG);
			default: allowed = cmd_new & ~busy;
		endcase
	end

	assign go_prog  = allowed & permit &
		(cmd_hold == flash_status_pkg::CMD_PAGE_PROGRAM);
	assign go_erase = allowed & permit &
		(cmd_hold == flash_status_pkg::CMD_SECTOR_ERASE);
	assign go_whole = allowed & permit & (range_eff == 3'h0) &
		(cmd_hold == flash_status_pkg::CMD_WHOLE_ARRAY_ERASE);
	assign go_write = allowed & permit & is_cmd_wrr & ~hw_protected;
	assign go_reset = allowed &
		(cmd_hold == flash_status_pkg::CMD_SOFTWARE_RESET);
	assign go_clear = allowed &
		(cmd_hold == flash_status_pkg::CMD_CLEAR_STATUS);

	// outcome of the running operation as the engine reports it
	assign fail_prog  = i_op_done & (state == flash_status_pkg::ST_PROG) &
		(i_op_fail | i_target_protected);
	assign fail_erase = i_op_done & ((state == flash_status_pkg::ST_ERASE &
		(i_op_fail | i_target_protected)) |
		(state == flash_status_pkg::ST_WHOLE & i_op_fail));
	assign fail_write = i_op_done & (state == flash_status_pkg::ST_WRITE) &
		i_op_fail;
	assign done_ok    = i_op_done & busy & (state != flash_status_pkg::ST_FAILED)
		& ~fail_prog & ~fail_erase & ~fail_write;

	always_comb begin
		next_state = state;
		case (state)
			flash_status_pkg::ST_IDLE: begin
				if (go_prog) begin
					next_state = flash_status_pkg::ST_PROG;
				end else if (go_erase) begin
					next_state = flash_status_pkg::ST_ERASE;
				end else if (go_whole) begin
					next_state = flash_status_pkg::ST_WHOLE;
				end else if (go_write) begin
					next_state = flash_status_pkg::ST_WRITE;
				end
			end
			flash_status_pkg::ST_PROG,
			flash_status_pkg::ST_ERASE,
			flash_status_pkg::ST_WHOLE,
			flash_status_pkg::ST_WRITE: begin
				if (fail_prog | fail_erase | fail_write) begin
					next_state = flash_status_pkg::ST_FAILED;
				end else if (i_op_done) begin
					next_state = flash_status_pkg::ST_IDLE;
				end
			end
			flash_status_pkg::ST_FAILED: begin
				if (go_clear) begin
					next_state = flash_status_pkg::ST_IDLE;
				end
			end
			default: next_state = flash_status_pkg::ST_IDLE;
		endcase
		if (go_reset) begin
			next_state = flash_status_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state <= flash_status_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// write-permit latch
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || go_reset) begin
			permit <= 1'b0;
		end else if (done_ok) begin
			permit <= 1'b0;
		end else if (allowed &&
				cmd_hold == flash_status_pkg::CMD_WRITE_PERMIT_SET) begin
			permit <= 1'b1;
		end else if (allowed &&
				cmd_hold == flash_status_pkg::CMD_WRITE_PERMIT_CLR) begin
			permit <= 1'b0;
		end
	end

	// failure flags: a failure in the clearing cycle still lands
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			prog_err  <= 1'b0;
			erase_err <= 1'b0;
		end else begin
			if (fail_prog | fail_write) begin
				prog_err <= 1'b1;
			end else if (go_clear | go_reset) begin
				prog_err <= 1'b0;
			end
			if (fail_erase) begin
				erase_err <= 1'b1;
			end else if (go_clear | go_reset) begin
				erase_err <= 1'b0;
			end
		end
	end

	// volatile range copy; the nonvolatile ones reload from the stored image
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || go_reset) begin
			range_vol <= flash_status_pkg::RANGE_VOL_RESET;
		end else if (go_write && i_protect_volatility_select &&
				!i_protect_freeze) begin
			range_vol <= data_hold[flash_status_pkg::BIT_RANGE_HI:
				flash_status_pkg::BIT_RANGE_LO];
		end
	end

	// pending image is written by the engine and only takes effect on success
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			lock       <= i_nv_image[3];
			range_nv   <= i_nv_image[2:0];
			o_nv_image <= i_nv_image;
		end else if (go_write) begin
			o_nv_image[3] <= data_hold[flash_status_pkg::BIT_LOCK];
			if (!i_protect_volatility_select && !i_protect_freeze) begin
				o_nv_image[2:0] <= data_hold[flash_status_pkg::BIT_RANGE_HI:
					flash_status_pkg::BIT_RANGE_LO];
			end else begin
				o_nv_image[2:0] <= range_nv;
			end
		end else if (done_ok && state == flash_status_pkg::ST_WRITE) begin
			lock     <= o_nv_image[3];
			range_nv <= o_nv_image[2:0];
		end
	end

	// engine strobes
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_op_start        <= 1'b0;
			o_op_kind         <= flash_status_pkg::KIND_PROGRAM;
			o_erase_suspend   <= 1'b0;
			o_program_suspend <= 1'b0;
			o_soft_reset      <= 1'b0;
		end else begin
			o_op_start <= (~busy) & (go_prog | go_erase | go_whole | go_write);
			if (go_erase) begin
				o_op_kind <= flash_status_pkg::KIND_ERASE;
			end else if (go_whole) begin
				o_op_kind <= flash_status_pkg::KIND_WHOLE;
			end else if (go_write) begin
				o_op_kind <= flash_status_pkg::KIND_WRITE;
			end else if (go_prog) begin
				o_op_kind <= flash_status_pkg::KIND_PROGRAM;
			end
			o_erase_suspend   <= allowed &
				(cmd_hold == flash_status_pkg::CMD_ERASE_SUSPEND);
			o_program_suspend <= allowed &
				(cmd_hold == flash_status_pkg::CMD_PROGRAM_SUSPEND);
			o_soft_reset      <= go_reset;
		end
	end

	assign status_now = {lock, prog_err, erase_err, range_eff, permit, busy};

	// status mirrors and the snapshot sent to the link side
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_status        <= 8'h00;
			o_protect_range <= 3'h0;
			shadow          <= 8'h00;
			shadow_req      <= 1'b0;
		end else begin
			o_status        <= status_now;
			o_protect_range <= range_eff;
			if (ack_s2 == shadow_req && shadow != status_now) begin
				shadow     <= status_now;
				shadow_req <= ~shadow_req;
			end
		end
	end

endmodule : flash_status_register_logic

/* File: bench/flash_status_register_logic_props.sv */
// port assertions for the status register one logic
`timescale 1ns/1ps
module flash_status_register_logic_props (
	input wire logic       i_ref_clk,
	input wire logic       i_sys_rst,
	input wire logic       i_wp_n,
	input wire logic       i_op_done,
	input wire logic       i_op_fail,
	input wire logic       i_target_protected,
	input wire logic       o_op_start,
	input wire logic [1:0] o_op_kind,
	input wire logic       o_erase_suspend,
	input wire logic       o_soft_reset,
	input wire logic [2:0] o_protect_range,
	input wire logic [7:0] o_status
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_sys_rst);

	AST_PROG_FLAG_CAUSE: assert property ($rose(o_status[6]) |->
		$past(i_op_done, 2) && $past(i_op_fail || i_target_protected, 2))
		else $error("program flag rose without a failed operation");
	AST_ERASE_FLAG_CAUSE: assert property ($rose(o_status[5]) |->
		$past(i_op_done, 2) && $past(i_op_fail || i_target_protected, 2))
		else $error("erase flag rose without a failed operation");
	AST_FLAG_HOLDS_BUSY: assert property ((o_status[6] || o_status[5]) |->
		o_status[0])
		else $error("failure flag set while not busy");
	AST_FAIL_KEEPS_BUSY: assert property (i_op_done && i_op_fail &&
		o_status[0] |-> ##2 o_status[0] && (o_status[6] || o_status[5]))
		else $error("failed operation did not keep busy");
	AST_SUCCESS_CLEARS: assert property (i_op_done && !i_op_fail &&
		!i_target_protected && o_status[0] |-> ##2 o_status[1:0] == 2'b00)
		else $error("successful operation left latch or busy set");
	AST_START_NEEDS_PERMIT: assert property (o_op_start |->
		o_status[1])
		else $error("operation started without write permit");
	AST_START_WHEN_IDLE: assert property (o_op_start |-> !o_status[0]
		##2 o_status[0])
		else $error("operation start while busy or busy not raised");
	AST_WHOLE_NEEDS_ZERO: assert property (o_op_start &&
		o_op_kind == 2'b10 |-> o_protect_range == 3'h0)
		else $error("whole erase started with range set");
	AST_LOCKED_WRITE: assert property (o_op_start &&
		o_op_kind == 2'b11 |-> !(o_status[7] && !i_wp_n))
		else $error("register write started while hardware locked");
	AST_SUSPEND_BUSY: assert property (o_erase_suspend |->
		o_status[0])
		else $error("erase suspend while idle");
	AST_SOFT_RESET_CLEARS: assert property (o_soft_reset |->
		##[1:4] o_status[1:0] == 2'b00)
		else $error("soft reset left latch or busy set");
endmodule : flash_status_register_logic_props

bind flash_status_register_logic flash_status_register_logic_props
	flash_status_register_logic_props_inst (.*);

/* File: bench/flash_host_model.sv */
// serial host model: mode 0 frames, clock only inside frames
`timescale 1ns/1ps
module flash_host_model (
	output logic      o_spi_clk,
	output logic      o_cs_n,
	output logic      o_mosi,
	input  wire logic i_miso
);
	initial begin
		o_spi_clk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end

	// bits beyond the first byte are read back msb first
	task automatic frame(input logic [15:0] dout, input int nbits,
			output logic [7:0] din);
		din = 8'h00;
		o_cs_n = 1'b0;
		#13;
		for (int k = 0; k < nbits; k++) begin
			o_mosi = dout[nbits - 1 - k];
			#24 o_spi_clk = 1'b1;
			if (k >= 8)
				din = {din[6:0], i_miso};
			#24 o_spi_clk = 1'b0;
		end
		#24 o_cs_n = 1'b1;
		// released line must not look like held data
		o_mosi = ~o_mosi;
		// spacing lets the command toggle cross into the core
		#1100;
	endtask : frame
endmodule : flash_host_model

/* File: bench/flash_status_register_logic_tb_top.sv */
// self-checking bench for the status register one logic
`timescale 1ns/1ps
module flash_status_register_logic_tb_top;
	logic       i_ref_clk, i_sys_rst, i_wp_n, i_op_done, i_op_fail;
	logic       i_target_protected, vol_sel, freeze;
	logic [3:0] nv;
	logic       spi_clk, cs_n, mosi, miso, miso_oe, op_start;
	logic       esus, psus, srst;
	logic [1:0] op_kind;
	logic [3:0] nv_out;
	logic [7:0] status, starts, esus_n, psus_n, srst_n;
	logic [2:0] prange;
	int         fail_count = 0;
	int         cmp_count = 0;
	int         cyc = 0;

	flash_status_register_logic flash_status_register_logic_inst (
		.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_spi_clk(spi_clk),
		.i_cs_n(cs_n), .i_mosi(mosi), .i_wp_n(i_wp_n), .o_miso(miso),
		.o_miso_oe(miso_oe), .i_protect_volatility_select(vol_sel),
		.i_protect_freeze(freeze), .i_nv_image(nv), .o_nv_image(nv_out),
		.i_op_done(i_op_done), .i_op_fail(i_op_fail),
		.i_target_protected(i_target_protected), .o_op_start(op_start),
		.o_op_kind(op_kind), .o_erase_suspend(esus),
		.o_program_suspend(psus), .o_soft_reset(srst),
		.o_protect_range(prange), .o_status(status));

	flash_host_model flash_host_model_inst (.o_spi_clk(spi_clk),
		.o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));

	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	initial begin
		{starts, esus_n, psus_n, srst_n} = 32'h0;
		// reset stands from time zero so no state is seen undefined
		{i_sys_rst, i_wp_n, i_op_done, i_op_fail} = 4'hd;
		{i_target_protected, vol_sel, freeze, nv} = 7'h00;
	end

	always @(posedge i_ref_clk) begin
		starts <= starts + 8'(op_start);
		esus_n <= esus_n + 8'(esus);
		psus_n <= psus_n + 8'(psus);
		srst_n <= srst_n + 8'(srst);
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	task automatic check8(string n, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : check8

	task automatic rst();
		@(posedge i_ref_clk) i_sys_rst <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
	endtask : rst

	task automatic cmd(logic [7:0] c);
		logic [7:0] d;
		flash_host_model_inst.frame({8'h00, c}, 8, d);
	endtask : cmd

	task automatic wrreg(logic [7:0] v);
		logic [7:0] d;
		flash_host_model_inst.frame({8'h01, v}, 16, d);
	endtask : wrreg

	task automatic rdsr(logic [7:0] e);
		logic [7:0] d;
		flash_host_model_inst.frame({8'h05, 8'h00}, 16, d);
		check8("serial status", e, d);
		check8("status port", e, status);
		check8("protect range", {5'h00, e[4:2]}, {5'h00, prange});
	endtask : rdsr

	task automatic op_check(logic [7:0] n, logic [1:0] k);
		check8("start count", n, starts);
		check8("op kind", {6'h00, k}, {6'h00, op_kind});
	endtask : op_check

	task automatic finish_op(logic f, logic p);
		@(posedge i_ref_clk);
		i_op_done <= 1'b1;
		i_op_fail <= f;
		i_target_protected <= p;
		@(posedge i_ref_clk) i_op_done <= 1'b0;
		repeat (6) @(posedge i_ref_clk);
	endtask : finish_op

	initial begin
		rst();
		rdsr(8'h00);
		cmd(8'h02);
		check8("start count", 8'h00, starts);
		cmd(8'h06);
		rdsr(8'h02);
		cmd(8'h04);
		rdsr(8'h00);
		cmd(8'h06);
		cmd(8'h02);
		op_check(8'h01, 2'b00);
		cmd(8'h04);
		rdsr(8'h03);
		finish_op(1'b0, 1'b0);
		rdsr(8'h00);
		cmd(8'h06);
		wrreg(8'h9c);
		op_check(8'h02, 2'b11);
		finish_op(1'b0, 1'b0);
		rdsr(8'h9c);
		check8("nv image", 8'h0f, {4'h0, nv_out});
		cmd(8'h06);
		cmd(8'h60);
		rdsr(8'h9e);
		@(posedge i_ref_clk) i_wp_n <= 1'b0;
		wrreg(8'h00);
		rdsr(8'h9e);
		@(posedge i_ref_clk) i_wp_n <= 1'b1;
		wrreg(8'h00);
		op_check(8'h03, 2'b11);
		finish_op(1'b0, 1'b0);
		cmd(8'h06);
		cmd(8'h02);
		finish_op(1'b1, 1'b0);
		rdsr(8'h43);
		cmd(8'h02);
		op_check(8'h04, 2'b00);
		cmd(8'h30);
		rdsr(8'h02);
		cmd(8'h04);
		cmd(8'h06);
		cmd(8'hd8);
		cmd(8'h85);
		cmd(8'h75);
		check8("suspends", 8'h10, {esus_n[3:0], psus_n[3:0]});
		finish_op(1'b0, 1'b1);
		rdsr(8'h23);
		cmd(8'h30);
		cmd(8'h75);
		check8("erase suspends", 8'h01, esus_n);
		cmd(8'h06);
		cmd(8'h60);
		op_check(8'h06, 2'b10);
		finish_op(1'b0, 1'b1);
		rdsr(8'h00);
		cmd(8'h06);
		cmd(8'hf0);
		check8("soft resets", 8'h01, srst_n);
		rdsr(8'h00);
		@(posedge i_ref_clk);
		nv <= 4'h8;
		vol_sel <= 1'b1;
		rst();
		rdsr(8'h9c);
		@(posedge i_ref_clk);
		freeze <= 1'b1;
		cmd(8'h06);
		wrreg(8'h00);
		finish_op(1'b0, 1'b0);
		rdsr(8'h1c);
		stop_test();
	end
endmodule : flash_status_register_logic_tb_top
